// [aomc_pkg.sv]
package aomc_pkg;

   // Register byte offsets.
   localparam logic [3:0] OFS_CTRL   = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h4;
   localparam logic [3:0] OFS_DATA   = 4'h8;
   localparam logic [3:0] OFS_LEVEL  = 4'hc;

   // Control register fields and reset value.
   localparam int         CTRL_SOFT_STANDBY = 0;
   localparam int         CTRL_CAPTURE_EN   = 1;
   localparam logic [1:0] CTRL_RESET        = 2'h0;

   // Status register fields.
   localparam int STAT_STANDBY    = 0;
   localparam int STAT_TWOS       = 1;
   localparam int STAT_STABILIZER = 2;
   localparam int STAT_REF_LO     = 3;
   localparam int STAT_SETTLED    = 5;
   localparam int STAT_OVERFLOW   = 6;

   // Capture data register: word in the low bits, valid flag above it.
   localparam int DATA_VALID = 16;

   // Quantised levels of the four-level mode input.
   localparam logic [1:0] MODE_GROUND     = 2'h0;
   localparam logic [1:0] MODE_ONE_THIRD  = 2'h1;
   localparam logic [1:0] MODE_TWO_THIRDS = 2'h2;
   localparam logic [1:0] MODE_SUPPLY     = 2'h3;

   // Reference states, indexed by the sense comparator result.
   localparam logic [1:0] REF_FIXED_1V0 = 2'h0;
   localparam logic [1:0] REF_PROGRAM   = 2'h1;
   localparam logic [1:0] REF_FIXED_0V5 = 2'h2;
   localparam logic [1:0] REF_EXTERNAL  = 2'h3;

   // Pipeline latency and output width.
   localparam int LATENCY_CYCLES = 7;
   localparam int SAMPLE_BITS    = 12;

   // Wake-up time after standby at the 100 MHz clock.
   localparam int CLK_KHZ      = 100000;
   localparam int WAKE_TIME_MS = 7;
   localparam int WAKE_CYCLES  = WAKE_TIME_MS * CLK_KHZ;

   // AXI response codes.
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   typedef enum logic [1:0] {ST_RUN, ST_STANDBY, ST_WAKE} aomc_state_t;

endpackage

// [aomc_adc_output.sv]
// Summary of operation
// - Each sample appears on the latched outputs exactly seven clocks after it was taken.
// - The output word changes right after each rising clock edge.
// - The output word is twelve bits with a separate enable for each bit driver.
// - A high standby input shuts down the reference, its buffer and the bias networks.
// - In standby every data output driver is released to high impedance.
// - When standby returns low, conversion resumes and the outputs are driven again.
// - Output words are coded as offset binary or twos complement by the mode input.
// - Mode supply, 2/3, 1/3 and ground select twos/off, twos/on, binary/on, binary/off.
// - The sense level selects external, fixed 0.5 V, programmable or fixed 1.0 V reference.
// - Each input sample is taken on the rising clock edge.
//
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps

module aomc_fifo
#(
   parameter int WIDTH = 12,
   parameter int DEPTH = 16
)
(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);

   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH)
      begin : g_bad_depth
         $error("FIFO depth must be a power of two of at least 2.");
      end
   endgenerate

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   logic [AW:0]      next_wr_ptr;
   logic [AW:0]      next_rd_ptr;
   logic             push;
   logic             pop;

   always_comb
   begin
      level       = wr_ptr - rd_ptr;
      in_ready    = (level != (AW+1)'(DEPTH));
      out_valid   = (level != '0);
      out_data    = mem[rd_ptr[AW-1:0]];
      push        = in_valid && in_ready;
      pop         = out_valid && out_ready;
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else
      begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
   end

   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end
endmodule

module aomc_adc_output
   import aomc_pkg::*;
#(
   parameter int LATENCY    = LATENCY_CYCLES,
   parameter int BITS       = SAMPLE_BITS,
   parameter int WAKE_COUNT = WAKE_CYCLES,
   parameter int FIFO_DEPTH = 16
)
(
   input  wire logic            clk,
   input  wire logic            rst_n,
   input  wire logic [BITS-1:0] sample_in,
   input  wire logic            standby_control_input,
   input  wire logic [1:0]      mode_level,
   input  wire logic [1:0]      sense_level,
   output logic [BITS-1:0]      data_out,
   output logic [BITS-1:0]      data_out_oe,
   output logic                 data_settled,
   output logic                 duty_cycle_stabilizer,
   output logic                 reference_enable,
   output logic [1:0]           reference_state,
   input  wire logic [3:0]      s_axi_awaddr,
   input  wire logic            s_axi_awvalid,
   output logic                 s_axi_awready,
   input  wire logic [31:0]     s_axi_wdata,
   input  wire logic [3:0]      s_axi_wstrb,
   input  wire logic            s_axi_wvalid,
   output logic                 s_axi_wready,
   output logic [1:0]           s_axi_bresp,
   output logic                 s_axi_bvalid,
   input  wire logic            s_axi_bready,
   input  wire logic [3:0]      s_axi_araddr,
   input  wire logic            s_axi_arvalid,
   output logic                 s_axi_arready,
   output logic [31:0]          s_axi_rdata,
   output logic [1:0]           s_axi_rresp,
   output logic                 s_axi_rvalid,
   input  wire logic            s_axi_rready
);
   localparam int LW = $clog2(FIFO_DEPTH) + 1;

   generate
      if (LATENCY < 1 || BITS < 2 || BITS > DATA_VALID || WAKE_COUNT < 1)
      begin : g_bad_param
         $error("Latency, width or wake count out of range.");
      end
   endgenerate

   // Returns {twos complement, stabilizer on} for a mode level.
   function automatic logic [1:0] decode_mode(input logic [1:0] lvl);
      logic [1:0] r;
      r = 2'h0;
      if (lvl == MODE_SUPPLY)
         r = 2'h2;
      else if (lvl == MODE_TWO_THIRDS)
         r = 2'h3;
      else if (lvl == MODE_ONE_THIRD)
         r = 2'h1;
      return r;
   endfunction

   logic [1:0]      ctrl;
   logic [1:0]      next_ctrl;
   logic            overflow;
   logic            next_overflow;
   logic [BITS-1:0] stage [LATENCY];
   logic [BITS-1:0] next_stage [LATENCY];
   logic [BITS-1:0] next_data_out;
   logic [BITS-1:0] next_data_out_oe;
   logic            next_stab;
   logic [1:0]      next_ref_state;
   logic [1:0]      mode_bits;
   logic            standby;

   aomc_state_t     state;
   aomc_state_t     next_state;
   logic [31:0]     wake_cnt;
   logic [31:0]     next_wake_cnt;
   logic            next_settled;
   logic            next_ref_enable;

   logic            cap_valid;
   logic            cap_ready;
   logic [BITS-1:0] fifo_data;
   logic            fifo_valid;
   logic            fifo_pop;
   logic [LW-1:0]   fifo_level;

   // Every stage of the sample pipeline and the output latch.
   always_comb
   begin
      standby       = standby_control_input || ctrl[CTRL_SOFT_STANDBY];
      mode_bits     = decode_mode(mode_level);
      next_stage[0] = sample_in;
      for (int i = 1; i < LATENCY; i++)
      begin
         next_stage[i] = stage[i-1];
      end
      next_data_out = stage[LATENCY-1];
      if (mode_bits[1])
      begin
         next_data_out[BITS-1] = ~stage[LATENCY-1][BITS-1];
      end
      next_data_out_oe = standby ? '0 : '1;
      next_stab        = mode_bits[0];
      next_ref_state   = sense_level;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < LATENCY; i++)
         begin
            stage[i] <= '0;
         end
         data_out              <= '0;
         data_out_oe           <= '0;
         duty_cycle_stabilizer <= 1'b0;
         reference_state       <= REF_FIXED_1V0;
      end
      else
      begin
         stage                 <= next_stage;
         data_out              <= next_data_out;
         data_out_oe           <= next_data_out_oe;
         duty_cycle_stabilizer <= next_stab;
         reference_state       <= next_ref_state;
      end
   end

   // Standby and wake-up sequencing.
   always_comb
   begin
      next_state      = state;
      next_wake_cnt   = wake_cnt;
      case (state)
         ST_RUN:
         begin
            if (standby)
               next_state = ST_STANDBY;
         end
         ST_STANDBY:
         begin
            if (!standby)
            begin
               next_state    = ST_WAKE;
               next_wake_cnt = 32'(WAKE_COUNT - 1);
            end
         end
         ST_WAKE:
         begin
            if (standby)
               next_state = ST_STANDBY;
            else if (wake_cnt == '0)
               next_state = ST_RUN;
            else
               next_wake_cnt = wake_cnt - 1'b1;
         end
         default:
            next_state = ST_RUN;
      endcase
      next_settled    = (next_state == ST_RUN);
      next_ref_enable = (next_state != ST_STANDBY);
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state            <= ST_RUN;
         wake_cnt         <= '0;
         data_settled     <= 1'b1;
         reference_enable <= 1'b1;
      end
      else
      begin
         state            <= next_state;
         wake_cnt         <= next_wake_cnt;
         data_settled     <= next_settled;
         reference_enable <= next_ref_enable;
      end
   end

   // Capture buffer filled from the output latch, drained by software.
   assign cap_valid = ctrl[CTRL_CAPTURE_EN] && data_settled && !standby;

   aomc_fifo #(.WIDTH(BITS), .DEPTH(FIFO_DEPTH)) u_fifo
   (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_data   (data_out),
      .in_valid  (cap_valid),
      .in_ready  (cap_ready),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop),
      .level     (fifo_level)
   );

   // Register bus slave.
   logic        aw_held;
   logic        w_held;
   logic [3:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        next_aw_held;
   logic        next_w_held;
   logic [3:0]  next_aw_addr;
   logic [31:0] next_w_data;
   logic [3:0]  next_w_strb;
   logic        next_awready;
   logic        next_wready;
   logic        next_bvalid;
   logic [1:0]  next_bresp;
   logic        next_arready;
   logic        next_rvalid;
   logic [31:0] next_rdata;
   logic [1:0]  next_rresp;
   logic        do_write;
   logic        ar_take;

   always_comb
   begin
      next_aw_held  = aw_held;
      next_w_held   = w_held;
      next_aw_addr  = aw_addr;
      next_w_data   = w_data;
      next_w_strb   = w_strb;
      next_bvalid   = s_axi_bvalid && !s_axi_bready;
      next_bresp    = s_axi_bresp;
      next_ctrl     = ctrl;
      next_overflow = overflow;
      if (s_axi_awvalid && s_axi_awready)
      begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      do_write = next_aw_held && next_w_held && !next_bvalid;
      if (do_write)
      begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = RESP_OKAY;
         if (next_aw_addr == OFS_CTRL)
         begin
            if (next_w_strb[0])
               next_ctrl = next_w_data[1:0];
         end
         else if (next_aw_addr == OFS_STATUS)
         begin
            if (next_w_strb[0] && next_w_data[STAT_OVERFLOW])
               next_overflow = 1'b0;
         end
         else if (next_aw_addr != OFS_DATA && next_aw_addr != OFS_LEVEL)
            next_bresp = RESP_DECERR;
      end
      if (cap_valid && !cap_ready)
         next_overflow = 1'b1;
      next_awready = !next_aw_held && !next_bvalid;
      next_wready  = !next_w_held && !next_bvalid;

      ar_take      = s_axi_arvalid && s_axi_arready;
      next_rvalid  = s_axi_rvalid && !s_axi_rready;
      next_rdata   = s_axi_rdata;
      next_rresp   = s_axi_rresp;
      fifo_pop     = 1'b0;
      if (ar_take)
      begin
         next_rvalid = 1'b1;
         next_rdata  = '0;
         next_rresp  = RESP_OKAY;
         if (s_axi_araddr == OFS_CTRL)
            next_rdata[1:0] = ctrl;
         else if (s_axi_araddr == OFS_STATUS)
         begin
            next_rdata[STAT_STANDBY]                = (state == ST_STANDBY);
            next_rdata[STAT_TWOS]                   = mode_bits[1];
            next_rdata[STAT_STABILIZER]             = duty_cycle_stabilizer;
            next_rdata[STAT_REF_LO+1:STAT_REF_LO]   = reference_state;
            next_rdata[STAT_SETTLED]                = data_settled;
            next_rdata[STAT_OVERFLOW]               = overflow;
         end
         else if (s_axi_araddr == OFS_DATA)
         begin
            next_rdata[BITS-1:0]  = fifo_data;
            next_rdata[DATA_VALID] = fifo_valid;
            fifo_pop              = 1'b1;
         end
         else if (s_axi_araddr == OFS_LEVEL)
            next_rdata[LW-1:0] = fifo_level;
         else
            next_rresp = RESP_DECERR;
      end
      next_arready = !next_rvalid;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_addr       <= '0;
         w_data        <= '0;
         w_strb        <= '0;
         ctrl          <= CTRL_RESET;
         overflow      <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
      end
      else
      begin
         aw_held       <= next_aw_held;
         w_held        <= next_w_held;
         aw_addr       <= next_aw_addr;
         w_data        <= next_w_data;
         w_strb        <= next_w_strb;
         ctrl          <= next_ctrl;
         overflow      <= next_overflow;
         s_axi_awready <= next_awready;
         s_axi_wready  <= next_wready;
         s_axi_bvalid  <= next_bvalid;
         s_axi_bresp   <= next_bresp;
         s_axi_arready <= next_arready;
         s_axi_rvalid  <= next_rvalid;
         s_axi_rdata   <= next_rdata;
         s_axi_rresp   <= next_rresp;
      end
   end
endmodule

// [aomc_adc_output_properties.sv]
`timescale 1ns/1ps
module aomc_adc_output_properties
   import aomc_pkg::*;
#(
   parameter int BITS       = SAMPLE_BITS,
   parameter int WAKE_COUNT = WAKE_CYCLES
)
(
   input wire logic            clk,
   input wire logic            rst_n,
   input wire logic [BITS-1:0] sample_in,
   input wire logic            standby_control_input,
   input wire logic [1:0]      mode_level,
   input wire logic [1:0]      sense_level,
   input wire logic [BITS-1:0] data_out,
   input wire logic [BITS-1:0] data_out_oe,
   input wire logic            data_settled,
   input wire logic            duty_cycle_stabilizer,
   input wire logic            reference_enable,
   input wire logic [1:0]      reference_state,
   input wire logic [1:0]      s_axi_bresp,
   input wire logic            s_axi_bvalid,
   input wire logic            s_axi_bready,
   input wire logic            s_axi_arvalid,
   input wire logic            s_axi_arready,
   input wire logic [31:0]     s_axi_rdata,
   input wire logic [1:0]      s_axi_rresp,
   input wire logic            s_axi_rvalid,
   input wire logic            s_axi_rready
);
   logic [3:0] cnt;
   logic [3:0] next_cnt;
   always_comb next_cnt = (cnt == 4'hf) ? cnt : cnt + 4'h1;
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
         cnt <= 4'h0;
      else
         cnt <= next_cnt;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_word_latency: assert property (cnt >= 4'h8 && data_out_oe == '1 && $stable(mode_level)
      |-> data_out == ($past(sample_in, 8) ^ {$past(mode_level[1]), {(BITS-1){1'b0}}}))
      else $error("output word does not follow its sample");
   a_standby_float: assert property (standby_control_input
      |=> data_out_oe == '0 && !reference_enable && !data_settled)
      else $error("standby did not release the drivers");
   a_wake_drive: assert property ($fell(standby_control_input)
      |=> data_out_oe == '1 && reference_enable) else $error("drivers not back after standby");
   a_wake_hold: assert property ($fell(standby_control_input)
      |=> !data_settled [*8] ##1 data_settled) else $error("settle delay is wrong");
   a_stab_decode: assert property (cnt >= 4'h2 |-> duty_cycle_stabilizer ==
      ($past(mode_level) == MODE_ONE_THIRD || $past(mode_level) == MODE_TWO_THIRDS))
      else $error("stabilizer decode is wrong");
   a_ref_copy: assert property (cnt >= 4'h2
      |-> reference_state == $past(sense_level)) else $error("reference state is wrong");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read data dropped");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   cover property ($fell(standby_control_input));
   cover property (s_axi_bvalid && s_axi_bready);
   cover property (s_axi_rvalid && s_axi_rresp == RESP_DECERR);
endmodule

bind aomc_adc_output aomc_adc_output_properties #(.BITS(BITS), .WAKE_COUNT(WAKE_COUNT)) u_props (
   .clk(clk), .rst_n(rst_n), .sample_in(sample_in),
   .standby_control_input(standby_control_input), .mode_level(mode_level),
   .sense_level(sense_level), .data_out(data_out), .data_out_oe(data_out_oe),
   .data_settled(data_settled), .duty_cycle_stabilizer(duty_cycle_stabilizer),
   .reference_enable(reference_enable), .reference_state(reference_state),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// [aomc_capture_model.sv]
`timescale 1ns/1ps
module aomc_capture_model
#(
   parameter int BITS = 12
)
(
   input  wire logic [BITS-1:0] data_out,
   input  wire logic [BITS-1:0] data_out_oe,
   input  wire logic            data_settled,
   input  wire logic            clk,
   output logic [BITS-1:0]      pad,
   output logic [BITS-1:0]      cap_word,
   output logic                 cap_valid
);
   logic [BITS-1:0] last = '0;
   // A released line floats, so it shows a level that changes every cycle.
   assign pad = (data_out_oe & data_out) | (~data_out_oe & ~last);
   initial cap_valid = 1'b0;
   always @(posedge clk)
   begin
      last <= pad;
      cap_word <= pad;
      cap_valid <= data_settled && (data_out_oe == '1);
   end
endmodule

// [aomc_adc_output_tb_top.sv]
`timescale 1ns/1ps
module aomc_adc_output_tb_top
   import aomc_pkg::*;
;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [11:0] sample_in = 12'h000;
   logic        standby_control_input = 1'b0;
   logic [1:0]  mode_level = 2'h0;
   logic [1:0]  sense_level = 2'h0;
   logic [11:0] data_out, data_out_oe, pad, cap_word, prev;
   logic        data_settled, stab, ref_en, cap_valid;
   logic [1:0]  ref_state, bresp, rresp, rsp;
   logic [3:0]  awaddr = 4'h0;
   logic [3:0]  araddr = 4'h0;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata, rd;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [7:0]  ecnt = 8'h00;
   logic [11:0] hist [256];
   int          mismatches = 0;
   int          n_tests = 0;
   int          cyc = 0;
   int          i;

   aomc_adc_output #(.WAKE_COUNT(8)) dut (
      .clk(clk), .rst_n(rst_n), .sample_in(sample_in),
      .standby_control_input(standby_control_input), .mode_level(mode_level),
      .sense_level(sense_level), .data_out(data_out), .data_out_oe(data_out_oe),
      .data_settled(data_settled), .duty_cycle_stabilizer(stab), .reference_enable(ref_en),
      .reference_state(ref_state), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   aomc_capture_model #(.BITS(12)) u_far (
      .data_out(data_out), .data_out_oe(data_out_oe), .data_settled(data_settled),
      .clk(clk), .pad(pad), .cap_word(cap_word), .cap_valid(cap_valid));

   always #5 clk = ~clk;

   task stop_test;
      if (mismatches == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   function logic [11:0] fmt(input logic [11:0] v);
      return v ^ {mode_level[1], 11'h000};
   endfunction

   task axw(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end while (!bvalid);
      rsp = bresp;
      bready <= 1'b0;
   endtask

   task axr(input logic [3:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (arready)
            arvalid <= 1'b0;
      end while (!rvalid);
      rd = rdata;
      rsp = rresp;
      rready <= 1'b0;
   endtask

   // Keeps each sample as taken, so the output can be checked seven cycles on.
   always @(posedge clk)
   begin
      hist[ecnt] = sample_in;
      ecnt <= ecnt + 8'h01;
      sample_in <= sample_in + 12'h1a7;
      cyc <= cyc + 1;
      if (cyc == 4000)
      begin
         mismatches++;
         stop_test;
      end
   end

   initial
   begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      axr(OFS_CTRL);
      check("ctrl reset", rd, 32'h0);
      axr(OFS_STATUS);
      check("status reset", rd, 32'h20);
      for (i = 0; i < 4; i++)
      begin
         @(posedge clk);
         mode_level <= i[1:0];
         sense_level <= i[1:0];
         repeat (10) @(negedge clk);
         check("word", data_out, fmt(hist[ecnt - 8'd8]));
         check("captured", cap_word, fmt(hist[ecnt - 8'd9]));
         check("stabilizer", stab, i == 1 || i == 2);
         check("reference", ref_state, i[1:0]);
         check("enables", data_out_oe, 12'hfff);
         axr(OFS_STATUS);
         check("status mode", rd[2:1], {i == 1 || i == 2, i[1]});
      end
      @(posedge clk);
      mode_level <= 2'h0;
      standby_control_input <= 1'b1;
      repeat (3) @(negedge clk);
      check("standby oe", data_out_oe, 12'h000);
      check("standby ref", ref_en, 1'b0);
      check("standby capture", cap_valid, 1'b0);
      axr(OFS_STATUS);
      check("status standby", rd[0], 1'b1);
      @(posedge clk);
      standby_control_input <= 1'b0;
      repeat (3) @(negedge clk);
      check("wake oe", data_out_oe, 12'hfff);
      check("wake settled", data_settled, 1'b0);
      check("wake capture", cap_valid, 1'b0);
      repeat (10) @(negedge clk);
      check("settled", data_settled, 1'b1);
      check("capture", cap_valid, 1'b1);
      axw(OFS_CTRL, 32'h1);
      check("ctrl resp", rsp, RESP_OKAY);
      repeat (2) @(negedge clk);
      check("soft standby oe", data_out_oe, 12'h000);
      axw(OFS_CTRL, 32'h2);
      repeat (40) @(negedge clk);
      axr(OFS_LEVEL);
      check("level full", rd, 32'h10);
      axr(OFS_STATUS);
      check("overflow", rd[6], 1'b1);
      axw(OFS_CTRL, 32'h0);
      axw(OFS_STATUS, 32'h40);
      axr(OFS_STATUS);
      check("overflow clear", rd[6], 1'b0);
      for (i = 0; i < 16; i++)
      begin
         axr(OFS_DATA);
         check("pop valid", rd[16], 1'b1);
         if (i > 0)
            check("pop step", 12'(rd[11:0] - prev), 12'h1a7);
         prev = rd[11:0];
      end
      axr(OFS_DATA);
      check("pop empty", rd[16], 1'b0);
      axr(OFS_LEVEL);
      check("level empty", rd, 32'h0);
      axw(4'h2, 32'h1);
      check("write decerr", rsp, RESP_DECERR);
      axr(4'h2);
      check("read decerr", rsp, RESP_DECERR);
      check("read decerr data", rd, 32'h0);
      axr(OFS_CTRL);
      check("ctrl kept", rd, 32'h0);
      stop_test;
   end
endmodule
